// ==== src/sync_ctrl_pkg.sv ====
// constants shared by the break/sync control block
package sync_ctrl_pkg;
    localparam int TIMER_W = 16;
    localparam int BIT_ERR_DIS = 10;
    localparam int BIT_TEST_MODE = 9;
    localparam int BIT_GATE = 8;
    localparam int STA_BREAK = 0;
    localparam int STA_COMPARE = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] MODE_UART = 2'h0;
    localparam logic [1:0] MODE_PW_READ = 2'h1;
    localparam logic [1:0] MODE_PW_WRITE = 2'h2;
    localparam int SYNC_RISES = 5;
    typedef enum {HUNT_BREAK, HUNT_SYNC, PASS} gate_t;
endpackage

// ==== src/break_timer.sv ====
// break timer: counts bus-low time, flags compare match and overflow
`timescale 1ns/100ps
`default_nettype none
module break_timer import sync_ctrl_pkg::*; #(
    parameter int W = TIMER_W
) (
    input wire logic mclk, // clock
    input wire logic nrst, // sync reset, low
    input wire logic fallEdge, // bus fell
    input wire logic riseEdge, // bus rose
    input wire logic [W-1:0] cmpVal, // compare value
    output logic [W-1:0] count, // running count
    output logic running, // timer active
    output logic cmpHit, // one-cycle match pulse
    output logic ovfHit // one-cycle overflow pulse
);
    logic [W-1:0] cnt_q, cnt_d;
    logic run_q, run_d, cmp_q, cmp_d, ovf_q, ovf_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        cmp_d = 1'b0;
        ovf_d = 1'b0;
        if (fallEdge) begin
            cnt_d = '0;
            run_d = 1'b1;
        end else if (riseEdge) begin
            run_d = 1'b0;
        end else if (run_q) begin
            cnt_d = cnt_q + 1'b1;
            cmp_d = (cnt_d == cmpVal);
            ovf_d = (cnt_q == '1);
            if (cnt_q == '1) run_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            cmp_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            cmp_q <= cmp_d;
            ovf_q <= ovf_d;
        end
    end

    assign count = cnt_q;
    assign running = run_q;
    assign cmpHit = cmp_q;
    assign ovfHit = ovf_q;
endmodule
`default_nettype wire

// ==== src/lin_sync_ctrl.sv ====
// LIN hardware sync control: test routing, receive gating, break interrupts
`timescale 1ns/100ps
`default_nettype none
module lin_sync_ctrl import sync_ctrl_pkg::*; #(
    parameter int W = TIMER_W
) (
    input wire logic mclk, // 250 MHz clock
    input wire logic nrst, // sync reset, low
    input wire logic errIntDis, // control bit 10
    input wire logic testMode, // control bit 9
    input wire logic gateRx, // control bit 8
    input wire logic ctrlWe, // load the three bits
    input wire logic [1:0] linMode, // uart, pulse read, pulse write
    input wire logic [W-1:0] cmpVal, // break timer compare value
    input wire logic cmpIntEn, // compare interrupt enable
    input wire logic staClr, // clear status flags
    input wire logic uartTx, // UART transmit
    input wire logic gpioTx, // general pin toward transceiver tx
    input wire logic xcvrRx, // transceiver receive
    output logic xcvrTx, // transceiver transmit
    output logic uartRx, // gated UART receive
    output logic gpioRx, // general pin from transceiver rx
    output logic [2:0] ctrlBits, // bits 10..8 readback
    output logic [W-1:0] breakTimerValue, // timer readback
    output logic [3:0] syncStatusReg, // sticky status flags
    output logic breakIrq, // interrupt request
    output logic errIrq // break timer error interrupt
);
    logic [2:0] ctrl_q, ctrl_d;
    logic rx_q, rx_d;
    logic xtx_q, xtx_d, urx_q, urx_d, grx_q, grx_d;
    logic [3:0] sta_q, sta_d;
    logic irq_q, irq_d, err_q, err_d;
    logic [W-1:0] tval_q;
    logic [2:0] rises_q, rises_d;
    gate_t gst_q, gst_d;
    logic fallEdge, riseEdge, running, cmpHit, ovfHit;
    logic [W-1:0] count;
    logic busIn;

    // in every mode the bus is seen through the transceiver alone
    assign busIn = xcvrRx;
    assign fallEdge = rx_q & ~busIn;
    assign riseEdge = ~rx_q & busIn;

    break_timer #(.W(W)) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .fallEdge(fallEdge),
        .riseEdge(riseEdge),
        .cmpVal(cmpVal),
        .count(count),
        .running(running),
        .cmpHit(cmpHit),
        .ovfHit(ovfHit)
    );

    // control bits
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrlWe) ctrl_d = {errIntDis, testMode, gateRx};
    end

    // break then sync detector for receive gating
    always_comb begin
        gst_d = gst_q;
        rises_d = rises_q;
        case (gst_q)
            HUNT_BREAK: begin
                if (ovfHit || (riseEdge && count != '0)) begin
                    gst_d = HUNT_SYNC;
                    rises_d = '0;
                end
            end
            HUNT_SYNC: begin
                // sync byte 0x55 gives five rising edges incl. stop
                if (riseEdge) begin
                    rises_d = rises_q + 1'b1;
                    if (rises_q + 1'b1 == 3'(SYNC_RISES)) gst_d = PASS;
                end
            end
            PASS: begin
                if (ovfHit) gst_d = HUNT_SYNC;
            end
            default: gst_d = HUNT_BREAK;
        endcase
        if (linMode != MODE_UART) gst_d = HUNT_BREAK;
    end

    // pin routing and status
    always_comb begin
        rx_d = busIn;
        sta_d = staClr ? 4'h0 : sta_q;
        irq_d = 1'b0;
        err_d = 1'b0;
        if (ctrl_q[1]) begin
            xtx_d = gpioTx;
            grx_d = xcvrRx;
            urx_d = 1'b1;
        end else begin
            xtx_d = uartTx;
            grx_d = 1'b1;
            // gate only while hunting with bit 8 set; bit 8 clear passes at once
            if (linMode == MODE_UART && ctrl_q[0] && gst_q != PASS)
                urx_d = 1'b1;
            else
                urx_d = busIn;
        end
        // set wins over clear
        if (riseEdge && linMode != MODE_UART && ctrl_q[0]) begin
            sta_d[STA_BREAK] = 1'b1;
            irq_d = 1'b1;
        end
        // write mode with bit 8 clear: nothing above fires
        if (cmpHit && cmpIntEn) begin
            sta_d[STA_COMPARE] = 1'b1;
            irq_d = 1'b1;
        end
        if (ovfHit) begin
            irq_d = 1'b1;
            err_d = ~ctrl_q[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RESET;
            rx_q <= 1'b1;
            xtx_q <= 1'b1;
            urx_q <= 1'b1;
            grx_q <= 1'b1;
            sta_q <= 4'h0;
            irq_q <= 1'b0;
            err_q <= 1'b0;
            tval_q <= '0;
            rises_q <= 3'h0;
            gst_q <= HUNT_BREAK;
        end else begin
            ctrl_q <= ctrl_d;
            rx_q <= rx_d;
            xtx_q <= xtx_d;
            urx_q <= urx_d;
            grx_q <= grx_d;
            sta_q <= sta_d;
            irq_q <= irq_d;
            err_q <= err_d;
            tval_q <= count;
            rises_q <= rises_d;
            gst_q <= gst_d;
        end
    end

    assign xcvrTx = xtx_q;
    assign uartRx = urx_q;
    assign gpioRx = grx_q;
    assign ctrlBits = ctrl_q;
    assign breakTimerValue = tval_q;
    assign syncStatusReg = sta_q;
    assign breakIrq = irq_q;
    assign errIrq = err_q;

    chk_err_masked: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q[2] |=> !errIrq) else $error("error irq while masked");
    chk_err_raised: assert property (@(posedge mclk) disable iff (!nrst)
        (ovfHit && !ctrl_q[2]) |=> errIrq) else $error("error irq missing");
    chk_test_route: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q[1] |=> xcvrTx == $past(gpioTx)) else $error("test route");
    chk_normal_route: assert property (@(posedge mclk) disable iff (!nrst)
        !ctrl_q[1] |=> xcvrTx == $past(uartTx)) else $error("uart route");
    chk_rx_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (!ctrl_q[1] && ctrl_q[0] && linMode == MODE_UART && gst_q != PASS)
        |=> uartRx) else $error("rx not gated");
    chk_rise_flag: assert property (@(posedge mclk) disable iff (!nrst)
        (riseEdge && linMode == MODE_PW_READ && ctrl_q[0])
        |=> syncStatusReg[STA_BREAK] && breakIrq) else $error("no break flag");
    chk_no_write_irq: assert property (@(posedge mclk) disable iff (!nrst)
        (linMode == MODE_PW_WRITE && !ctrl_q[0] && !cmpHit && !ovfHit)
        |=> !breakIrq) else $error("write mode irq");
    chk_timer_halt: assert property (@(posedge mclk) disable iff (!nrst)
        (riseEdge && !fallEdge) |=> !running ##1 $stable(count))
        else $error("timer kept running");
    chk_reset_bits: assert property (@(posedge mclk)
        !nrst |=> ctrlBits == 3'h0) else $error("ctrl not reset");
endmodule
`default_nettype wire

// ==== sim/bus_master_model.sv ====
// bus master model: drives the receive line with timed low pulses
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    input wire logic mclk, // clock
    output logic busLine // bus level seen by the transceiver
);
    // recessive level while idle, the bus has a pull-up
    initial busLine = 1'b1;
    task automatic hold(input logic v);
        @(negedge mclk) busLine = v;
    endtask
    // dominant pulse of n cycles, then an idle gap
    task automatic lowPulse(input int n);
        @(negedge mclk) busLine = 1'b0;
        repeat (n) @(negedge mclk);
        busLine = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// testbench for the LIN break/sync control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sync_ctrl_pkg::*;
    // short timer so that overflow comes quickly
    localparam int TW = 6;
    logic mclk, nrst, errIntDis, testMode, gateRx, ctrlWe, cmpIntEn, staClr;
    logic uartTx, gpioTx, xcvrRx, xcvrTx, uartRx, gpioRx, breakIrq, errIrq;
    logic [1:0] linMode;
    logic [TW-1:0] cmpVal, breakTimerValue, tv;
    logic [2:0] ctrlBits;
    logic [3:0] syncStatusReg;
    int fail_count = 0, check_count = 0, irqN = 0, errN = 0, n;
    typedef struct packed {logic t9, utx, gtx, rx, etx, grx;} row_t;
    row_t rows[4] = '{'{0, 0, 1, 0, 0, 1}, '{0, 1, 0, 0, 1, 1},
        '{1, 0, 1, 0, 1, 0}, '{1, 1, 0, 1, 0, 1}};
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    lin_sync_ctrl #(.W(TW)) lin_sync_ctrl_inst (.mclk(mclk), .nrst(nrst),
        .errIntDis(errIntDis), .testMode(testMode), .gateRx(gateRx),
        .ctrlWe(ctrlWe), .linMode(linMode), .cmpVal(cmpVal),
        .cmpIntEn(cmpIntEn), .staClr(staClr), .uartTx(uartTx),
        .gpioTx(gpioTx), .xcvrRx(xcvrRx), .xcvrTx(xcvrTx), .uartRx(uartRx),
        .gpioRx(gpioRx), .ctrlBits(ctrlBits),
        .breakTimerValue(breakTimerValue), .syncStatusReg(syncStatusReg),
        .breakIrq(breakIrq), .errIrq(errIrq));
    bus_master_model bus_master_model_inst (.mclk(mclk), .busLine(xcvrRx));
    always @(posedge mclk) begin
        if (breakIrq === 1'b1) irqN++;
        if (errIrq === 1'b1) errN++;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // load control bits and clear status in one go
    task automatic setc(input logic e, t, g, input logic [1:0] m);
        @(negedge mclk);
        {errIntDis, testMode, gateRx, linMode} = {e, t, g, m};
        ctrlWe = 1'b1;
        staClr = 1'b1;
        @(negedge mclk);
        ctrlWe = 1'b0;
        staClr = 1'b0;
        repeat (2) @(negedge mclk);
        chk(ctrlBits, {e, t, g});
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        results;
    end
    initial begin
        {nrst, errIntDis, testMode, gateRx, ctrlWe, cmpIntEn, staClr} = 7'h00;
        {uartTx, gpioTx} = 2'h3;
        linMode = MODE_UART;
        cmpVal = 6'h03;
        repeat (6) @(negedge mclk);
        chk(ctrlBits, CTRL_RESET);
        chk({xcvrTx, uartRx, gpioRx, syncStatusReg}, 7'h70);
        nrst = 1'b1;
        foreach (rows[i]) begin
            // bit 9 loaded with the row's t9 value first, then the pins given their row values
            setc(1'b0, rows[i].t9, 1'b0, MODE_UART);
            {uartTx, gpioTx} = {rows[i].utx, rows[i].gtx};
            bus_master_model_inst.hold(rows[i].rx);
            repeat (2) @(negedge mclk);
            chk({xcvrTx, gpioRx}, {rows[i].etx, rows[i].grx});
        end
        bus_master_model_inst.hold(1'b1);
        setc(1'b0, 1'b0, 1'b1, MODE_UART);
        bus_master_model_inst.hold(1'b0);
        repeat (3) @(negedge mclk);
        chk(uartRx, 1'b1);
        bus_master_model_inst.hold(1'b1);
        repeat (4) @(negedge mclk);
        repeat (SYNC_RISES) bus_master_model_inst.lowPulse(1);
        bus_master_model_inst.hold(1'b0);
        repeat (3) @(negedge mclk);
        chk(uartRx, 1'b0);
        bus_master_model_inst.hold(1'b1);
        setc(1'b0, 1'b0, 1'b0, MODE_UART);
        bus_master_model_inst.hold(1'b0);
        repeat (3) @(negedge mclk);
        chk(uartRx, 1'b0);
        bus_master_model_inst.hold(1'b1);
        setc(1'b0, 1'b0, 1'b1, MODE_PW_READ);
        n = irqN;
        bus_master_model_inst.lowPulse(5);
        chk({syncStatusReg[STA_BREAK], 15'(irqN - n)}, 16'h8001);
        tv = breakTimerValue;
        repeat (3) @(negedge mclk);
        chk(breakTimerValue, tv);
        chk(tv >= 6'h04 && tv <= 6'h06, 1'b1);
        cmpIntEn = 1'b1;
        cmpVal = 6'h05;
        bus_master_model_inst.lowPulse(8);
        chk(syncStatusReg[STA_COMPARE], 1'b1);
        cmpIntEn = 1'b0;
        // overflow needs more than 2**TW low cycles
        setc(1'b0, 1'b0, 1'b0, MODE_PW_READ);
        n = errN;
        bus_master_model_inst.lowPulse(80);
        chk(errN - n, 1);
        setc(1'b1, 1'b0, 1'b0, MODE_PW_READ);
        n = errN;
        bus_master_model_inst.lowPulse(80);
        chk(errN - n, 0);
        setc(1'b0, 1'b0, 1'b0, MODE_PW_WRITE);
        n = irqN;
        bus_master_model_inst.lowPulse(5);
        chk({syncStatusReg[STA_BREAK], 15'(irqN - n)}, 16'h0000);
        tv = breakTimerValue;
        repeat (3) @(negedge mclk);
        chk(breakTimerValue, tv);
        setc(1'b0, 1'b0, 1'b1, MODE_PW_WRITE);
        n = irqN;
        bus_master_model_inst.lowPulse(5);
        chk({syncStatusReg[STA_BREAK], 15'(irqN - n)}, 16'h8001);
        results;
    end
endmodule
`default_nettype wire
